// ===== inc/periph_irq_cfg.svh
// offsets, field positions and reset values of the flag bank and its controller
`ifndef PERIPH_IRQ_CFG_SVH
`define PERIPH_IRQ_CFG_SVH
`define ADDR_FLAGS_ONE   8'h0c
`define ADDR_FLAGS_TWO   8'h0d
`define ADDR_ENABLES_TWO 8'h8d
`define ADDR_RESET_CAUSE 8'h8e
`define BIT_PAR_PORT     7
`define BIT_CONV_DONE    6
`define BIT_RX_FULL      5
`define BIT_TX_EMPTY     4
`define BIT_SYNC_SERIAL  3
`define BIT_CAPCMP_ONE   2
`define BIT_PERIOD_MATCH 1
`define BIT_WIDE_OVF     0
`define BIT_CAPCMP_TWO   0
`define BIT_POR          1
`define BIT_BOR          0
`define FLAGS_STORED     8'hcf
`define FLAGS_RST        8'h00
`define ENABLE_RST       1'h0
`define POR_RST          1'h0
`define BOR_RST          1'h1
`define HOST_CTRL        6'h00
`define HOST_EVENT       6'h04
`define HOST_CMD         6'h08
`define HOST_DATA        6'h0c
`define EV_WIDTH         12
`define CMD_WRITE_BIT    16
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// ===== inc/periph_irq_pkg.sv
// types shared by the flag bank, its controller and the link between them
package periph_irq_pkg;
  typedef enum logic [1:0] {
    CC_OFF     = 2'b00,
    CC_CAPTURE = 2'b01,
    CC_COMPARE = 2'b10,
    CC_PWM     = 2'b11
  } capcmp_mode_t;
  typedef enum logic [1:0] {
    SSP_SPI        = 2'b00,
    SSP_I2C_SLAVE  = 2'b01,
    SSP_I2C_MASTER = 2'b10,
    SSP_OFF        = 2'b11
  } ssp_mode_t;
endpackage

// ===== inc/periph_irq_if.sv
// link between the peripheral flag bank and the party that drives it
`timescale 1ns/10ps
interface periph_irq_if;
  import periph_irq_pkg::*;
  logic [7:0]   reg_addr;
  logic         reg_wr;
  logic         reg_rd;
  logic [7:0]   reg_wdata;
  logic [7:0]   reg_rdata;
  logic         reg_rvalid;
  logic         psp_access;
  logic         adc_done;
  logic         rx_full;
  logic         tx_empty;
  ssp_mode_t    ssp_mode;
  logic         ssp_xfer_done;
  logic         ssp_seq_done;
  logic         ssp_idle;
  logic         bus_start_seen;
  logic         bus_stop_seen;
  capcmp_mode_t ccp1_mode;
  logic         ccp1_capture;
  logic         ccp1_match;
  capcmp_mode_t ccp2_mode;
  logic         ccp2_capture;
  logic         ccp2_match;
  logic [7:0]   narrow_timer_count;
  logic [7:0]   narrow_timer_period;
  logic         wide_timer_overflow;
  logic         bor_reset;
  modport device (
    input  reg_addr, reg_wr, reg_rd, reg_wdata, psp_access, adc_done, rx_full, tx_empty,
    input  ssp_mode, ssp_xfer_done, ssp_seq_done, ssp_idle, bus_start_seen, bus_stop_seen,
    input  ccp1_mode, ccp1_capture, ccp1_match, ccp2_mode, ccp2_capture, ccp2_match,
    input  narrow_timer_count, narrow_timer_period, wide_timer_overflow, bor_reset,
    output reg_rdata, reg_rvalid
  );
  modport host (
    output reg_addr, reg_wr, reg_rd, reg_wdata, psp_access, adc_done, rx_full, tx_empty,
    output ssp_mode, ssp_xfer_done, ssp_seq_done, ssp_idle, bus_start_seen, bus_stop_seen,
    output ccp1_mode, ccp1_capture, ccp1_match, ccp2_mode, ccp2_capture, ccp2_match,
    output narrow_timer_count, narrow_timer_period, wide_timer_overflow, bor_reset,
    input  reg_rdata, reg_rvalid
  );
endinterface

// ===== design/periph_irq_flags.sv
// peripheral interrupt flag bank with reset cause record
// Operation
// RULE1 - flags set regardless of any enable
// RULE2 - software clears flags before enabling them
// RULE3 - parallel port access sets bit 7, sticky
// RULE4 - small package: software keeps bit 7 clear
// RULE5 - conversion done sets bit 6, sticky
// RULE6 - bit 5 mirrors receive buffer full
// RULE7 - bit 4 mirrors transmit buffer empty
// RULE8 - serial transfer completion sets bit 3
// RULE9 - master sequence completion sets bit 3
// RULE10 - bus start or stop while idle sets bit 3
// RULE11 - capture or compare event sets bit 2
// RULE12 - second flag register holds only bit 0
// RULE13 - period match sets bit 1, sticky
// RULE14 - wide timer overflow sets bit 0, sticky
// RULE15 - second enable register holds only bit 0
// RULE16 - power-on reset clears power-on status
// RULE17 - brown-out reset clears brown-out status
// RULE18 - brown-out status undefined without detector
// RULE19 - reset cause upper six bits read zero
// RULE20 - group enable gates every peripheral interrupt
// RULE21 - request when enabled flag set, gated
`timescale 1ns/10ps
`include "periph_irq_cfg.svh"
module periph_irq_flags
  import periph_irq_pkg::*;
(
  // clock, reset and freeze
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  // peripherals and register access
  periph_irq_if.device    link,
  // core interrupt control
  input  wire logic       global_irq_enable,
  input  wire logic       peripheral_group_enable,
  input  wire logic [7:0] peripheral_enables_one,
  input  wire logic       brownout_detect_enable,
  output wire logic       periph_irq
);

  // capture or compare event per selected mode; pwm never flags
  function automatic logic capcmp_event(input capcmp_mode_t mode,
                                        input logic cap,
                                        input logic match);
    capcmp_event = ((mode == CC_CAPTURE) && cap) || ((mode == CC_COMPARE) && match);
  endfunction

  logic [7:0] flags_one;
  logic       capcmp_second_flag;
  logic       capcmp_second_enable;
  logic       por_status;
  logic       brownout_status;
  logic [7:0] rdata;
  logic       rvalid;
  logic [7:0] read_value;

  wire logic       sel_f1 = (link.reg_addr == `ADDR_FLAGS_ONE);
  wire logic       sel_f2 = (link.reg_addr == `ADDR_FLAGS_TWO);
  wire logic       sel_e2 = (link.reg_addr == `ADDR_ENABLES_TWO);
  wire logic       sel_rc = (link.reg_addr == `ADDR_RESET_CAUSE);
  wire logic       wr_f1  = link.reg_wr && sel_f1;
  wire logic       wr_f2  = link.reg_wr && sel_f2;
  wire logic       wr_e2  = link.reg_wr && sel_e2;
  wire logic       wr_rc  = link.reg_wr && sel_rc;
  wire logic       bor_hit = link.bor_reset && brownout_detect_enable;

  // RULE3 parallel port access
  wire logic par_port_access_flag_set = link.psp_access;
  // RULE5 conversion done event
  wire logic conversion_done_flag_set = link.adc_done;
  wire logic ssp_active  = (link.ssp_mode != SSP_OFF);
  wire logic ssp_master  = (link.ssp_mode == SSP_I2C_MASTER);
  // RULE8 transfer in any serial mode
  wire logic ssp_xfer    = ssp_active && link.ssp_xfer_done;
  // RULE9 master start, stop, restart, ack
  wire logic ssp_seq     = ssp_master && link.ssp_seq_done;
  // RULE10 foreign start or stop while idle
  wire logic ssp_bus     = ssp_master && link.ssp_idle && (link.bus_start_seen || link.bus_stop_seen);
  wire logic sync_serial_flag_set = ssp_xfer || ssp_seq || ssp_bus;
  // RULE11 first capture/compare event
  wire logic capcmp_first_flag_set = capcmp_event(link.ccp1_mode, link.ccp1_capture, link.ccp1_match);
  // RULE12 second capture/compare, same semantics
  wire logic capcmp_second_flag_set = capcmp_event(link.ccp2_mode, link.ccp2_capture, link.ccp2_match);
  // RULE13 narrow timer reaches its period
  wire logic period_match_flag_set = (link.narrow_timer_count == link.narrow_timer_period);
  // RULE14 wide timer overflow event
  wire logic wide_timer_overflow_flag_set = link.wide_timer_overflow;

  // RULE1 events set flags whatever the enables
  wire logic [7:0] flags_one_set = {par_port_access_flag_set,
                                    conversion_done_flag_set,
                                    2'b00,
                                    sync_serial_flag_set,
                                    capcmp_first_flag_set,
                                    period_match_flag_set,
                                    wide_timer_overflow_flag_set};

  // set wins over a software clear in the same cycle
  wire logic [7:0] flags_one_base  = wr_f1 ? link.reg_wdata : flags_one;
  wire logic [7:0] next_flags_one  = (flags_one_base | flags_one_set) & `FLAGS_STORED;
  wire logic       next_capcmp_two = (wr_f2 ? link.reg_wdata[`BIT_CAPCMP_TWO] : capcmp_second_flag)
                                     | capcmp_second_flag_set;
  wire logic       next_enable_two = wr_e2 ? link.reg_wdata[`BIT_CAPCMP_TWO] : capcmp_second_enable;
  wire logic       next_por        = wr_rc ? link.reg_wdata[`BIT_POR] : por_status;
  wire logic       next_bor        = wr_rc ? link.reg_wdata[`BIT_BOR] : brownout_status;

  // RULE6 receive buffer level, read live
  wire logic rx_full_flag  = link.rx_full;
  // RULE7 transmit buffer level, read live
  wire logic tx_empty_flag = link.tx_empty;

  wire logic [7:0] flags_one_view = {flags_one[`BIT_PAR_PORT],
                                     flags_one[`BIT_CONV_DONE],
                                     rx_full_flag,
                                     tx_empty_flag,
                                     flags_one[3:0]};

  // the flag bank; aresetn is the power-on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_one            <= `FLAGS_RST;
      capcmp_second_flag   <= 1'b0;
      capcmp_second_enable <= `ENABLE_RST;
    end else if (ce) begin
      if (bor_hit) begin
        flags_one            <= `FLAGS_RST;
        capcmp_second_flag   <= 1'b0;
        capcmp_second_enable <= `ENABLE_RST;
      end else begin
        flags_one            <= next_flags_one;
        capcmp_second_flag   <= next_capcmp_two;
        capcmp_second_enable <= next_enable_two;
      end
    end
  end

  // reset cause record
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // RULE16 power-on clears power-on status
      por_status      <= `POR_RST;
      // RULE18 brown-out status has no defined meaning here
      brownout_status <= `BOR_RST;
    end else if (ce) begin
      por_status <= next_por;
      // RULE17 brown-out reset clears its status
      if (bor_hit) begin
        brownout_status <= 1'b0;
      end else begin
        brownout_status <= next_bor;
      end
    end
  end

  // register read selection
  always_comb begin
    read_value = 8'h00;
    if (sel_f1) begin
      read_value = flags_one_view;
    end else if (sel_f2) begin
      // RULE12 bits 7 to 1 read zero
      read_value = {7'h00, capcmp_second_flag};
    end else if (sel_e2) begin
      // RULE15 lone enable bit, rest zero
      read_value = {7'h00, capcmp_second_enable};
    end else if (sel_rc) begin
      // RULE19 upper six bits read zero
      read_value = {6'h00, por_status, brownout_status};
    end
  end

  // read data one cycle after the request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else if (ce) begin
      rvalid <= link.reg_rd;
      if (link.reg_rd) begin
        rdata <= read_value;
      end
    end
  end

  assign link.reg_rdata  = rdata;
  assign link.reg_rvalid = rvalid;

  wire logic pending_one = |(flags_one_view & peripheral_enables_one);
  wire logic pending_two = capcmp_second_flag && capcmp_second_enable;

  // RULE20 group enable required
  // RULE21 request gated by group and global enable
  assign periph_irq = global_irq_enable && peripheral_group_enable && (pending_one || pending_two);

endmodule

// ===== design/periph_irq_host.sv
// peripheral side controller: drives events and register access from AXI4-Lite
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
`include "periph_irq_cfg.svh"
module periph_irq_host
  import periph_irq_pkg::*;
(
  // clock, reset and freeze
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // link to the flag bank
  periph_irq_if.host       link,
  // axi4-lite write address
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  // axi4-lite write response
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic known_addr(input logic [5:0] addr);
    known_addr = (addr == `HOST_CTRL) || (addr == `HOST_EVENT) ||
                 (addr == `HOST_CMD) || (addr == `HOST_DATA);
  endfunction

  logic [5:0]            aw_addr;
  logic                  aw_held;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  w_held;
  logic                  bvalid;
  logic [1:0]            bresp;
  logic                  rvalid;
  logic [1:0]            rresp;
  logic [31:0]           rdata;
  logic [31:0]           ctrl;
  logic [31:0]           cmd;
  logic [`EV_WIDTH-1:0]  events;
  logic                  acc_wr;
  logic                  acc_rd;
  logic [7:0]            dev_data;
  logic                  dev_pending;
  logic [31:0]           read_value;

  assign s_axi_awready = ce && !aw_held && !bvalid;
  assign s_axi_wready  = ce && !w_held && !bvalid;
  assign s_axi_arready = ce && !rvalid;

  wire logic        do_wr   = aw_held && w_held && !bvalid;
  wire logic [31:0] wmask   = strb_mask(w_strb);
  wire logic        wr_ctrl = do_wr && (aw_addr == `HOST_CTRL);
  wire logic        wr_ev   = do_wr && (aw_addr == `HOST_EVENT);
  wire logic        wr_cmd  = do_wr && (aw_addr == `HOST_CMD);
  wire logic [31:0] next_ctrl = (ctrl & ~wmask) | (w_data & wmask);
  wire logic [31:0] next_cmd  = (cmd & ~wmask) | (w_data & wmask);
  wire logic [31:0] ev_bits   = w_data & wmask;

  // write channel: address and data in either order, then response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr <= 6'h00;
      aw_held <= 1'b0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      w_held  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= known_addr(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && s_axi_bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // control word, event pulses and bank access commands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl        <= 32'h0;
      cmd         <= 32'h0;
      events      <= '0;
      acc_wr      <= 1'b0;
      acc_rd      <= 1'b0;
      dev_data    <= 8'h00;
      dev_pending <= 1'b0;
    end else if (ce) begin
      events <= wr_ev ? ev_bits[`EV_WIDTH-1:0] : '0;
      acc_wr <= wr_cmd && next_cmd[`CMD_WRITE_BIT];
      acc_rd <= wr_cmd && !next_cmd[`CMD_WRITE_BIT];
      if (wr_ctrl) begin
        ctrl <= next_ctrl;
      end
      if (wr_cmd) begin
        cmd <= next_cmd;
      end
      if (link.reg_rvalid) begin
        dev_data <= link.reg_rdata;
      end
      // a new read request wins over the completion of the last
      if (wr_cmd && !next_cmd[`CMD_WRITE_BIT]) begin
        dev_pending <= 1'b1;
      end else if (link.reg_rvalid) begin
        dev_pending <= 1'b0;
      end
    end
  end

  always_comb begin
    read_value = 32'h0;
    if (s_axi_araddr == `HOST_CTRL) begin
      read_value = ctrl;
    end else if (s_axi_araddr == `HOST_CMD) begin
      read_value = cmd;
    end else if (s_axi_araddr == `HOST_DATA) begin
      read_value = {23'h0, dev_pending, dev_data};
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rresp  <= `RESP_OKAY;
      rdata  <= 32'h0;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid <= 1'b1;
        rdata  <= read_value;
        rresp  <= known_addr(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && s_axi_rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp  = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp  = rresp;
  assign s_axi_rdata  = rdata;

  assign link.reg_addr            = cmd[15:8];
  assign link.reg_wdata           = cmd[7:0];
  assign link.reg_wr              = acc_wr;
  assign link.reg_rd              = acc_rd;
  assign link.ssp_mode            = ssp_mode_t'(ctrl[1:0]);
  assign link.ccp1_mode           = capcmp_mode_t'(ctrl[3:2]);
  assign link.ccp2_mode           = capcmp_mode_t'(ctrl[5:4]);
  assign link.ssp_idle            = ctrl[6];
  assign link.rx_full             = ctrl[7];
  assign link.tx_empty            = ctrl[8];
  assign link.narrow_timer_count  = ctrl[23:16];
  assign link.narrow_timer_period = ctrl[31:24];
  assign link.psp_access          = events[0];
  assign link.adc_done            = events[1];
  assign link.ssp_xfer_done       = events[2];
  assign link.ssp_seq_done        = events[3];
  assign link.bus_start_seen      = events[4];
  assign link.bus_stop_seen       = events[5];
  assign link.ccp1_capture        = events[6];
  assign link.ccp1_match          = events[7];
  assign link.ccp2_capture        = events[8];
  assign link.ccp2_match          = events[9];
  assign link.wide_timer_overflow = events[10];
  assign link.bor_reset           = events[11];

endmodule

// ===== test/periph_irq_monitor.sv
// concurrent checks on the link between the flag bank and its controller
`timescale 1ns/10ps
module periph_irq_monitor (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // bank access
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  // peripheral events and levels
  input wire logic       psp_access,
  input wire logic       adc_done,
  input wire logic       rx_full,
  input wire logic       tx_empty,
  input wire logic       wide_timer_overflow,
  input wire logic       bor_reset,
  input wire logic [7:0] narrow_timer_count,
  input wire logic [7:0] narrow_timer_period
);
  logic [7:0] seen;
  wire        wr_one = reg_wr && reg_addr == 8'h0c;
  wire  [7:0] ev_set = {psp_access, adc_done, 4'h0, narrow_timer_count == narrow_timer_period, wide_timer_overflow};
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // flags known to be set; a brown-out drops every claim
  always_ff @(posedge aclk) begin
    if (!aresetn || bor_reset) begin
      seen <= 8'h00;
    end else begin
      seen <= ev_set | (seen & (wr_one ? reg_wdata : 8'hff));
    end
  end
  sequence rd_at(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence rd_one;
    rd_at(8'h0c);
  endsequence
  chk_read_answer_next: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  chk_answer_single_pulse: assert property (!reg_rd |=> !reg_rvalid)
    else $error("answer without a read");
  chk_par_port_sticky: assert property ((rd_one and seen[7]) |=> reg_rdata[7])
    else $error("port flag lost");
  chk_conv_done_sticky: assert property ((rd_one and seen[6]) |=> reg_rdata[6])
    else $error("conversion flag lost");
  chk_period_match_set: assert property ((rd_one and seen[1]) |=> reg_rdata[1])
    else $error("period flag lost");
  chk_wide_ovf_sticky: assert property ((rd_one and seen[0]) |=> reg_rdata[0])
    else $error("overflow flag lost");
  chk_rx_full_live: assert property (rd_one |=> reg_rdata[5] == $past(rx_full))
    else $error("receive bit not live");
  chk_tx_empty_live: assert property (rd_one |=> reg_rdata[4] == $past(tx_empty))
    else $error("transmit bit not live");
  chk_flags_two_upper: assert property (rd_at(8'h0d) |=> reg_rdata[7:1] == 7'h00)
    else $error("second flag upper bits set");
  chk_enables_two_upper: assert property (rd_at(8'h8d) |=> reg_rdata[7:1] == 7'h00)
    else $error("second enable upper bits set");
  chk_cause_upper_zero: assert property (rd_at(8'h8e) |=> reg_rdata[7:2] == 6'h00)
    else $error("reset cause upper bits set");
endmodule

// ===== test/periph_irq_flags_reset_cause_tb.sv
// end-to-end bench: axi4-lite controller driving the peripheral flag bank
`timescale 1ns/10ps
`include "periph_irq_cfg.svh"
module periph_irq_flags_reset_cause_tb;
  localparam logic [31:0] BASE = 32'h0201_0000;
  logic aclk, aresetn, global_irq_enable, peripheral_group_enable, brownout_detect_enable;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [7:0] peripheral_enables_one;
  logic [31:0] s_axi_wdata, rd_word;
  logic [3:0] s_axi_wstrb;
  logic [1:0] resp;
  wire logic periph_irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int fails, checks_done;
  periph_irq_if lnk ();
  periph_irq_flags u_periph_irq_flags (.aclk, .aresetn, .ce(1'b1), .link(lnk), .global_irq_enable,
    .peripheral_group_enable, .peripheral_enables_one, .brownout_detect_enable, .periph_irq);
  periph_irq_host u_periph_irq_host (.aclk, .aresetn, .ce(1'b1), .link(lnk), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  periph_irq_monitor u_periph_irq_monitor (.aclk, .aresetn, .reg_addr(lnk.reg_addr), .reg_wr(lnk.reg_wr),
    .reg_rd(lnk.reg_rd), .reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata), .reg_rvalid(lnk.reg_rvalid),
    .psp_access(lnk.psp_access), .adc_done(lnk.adc_done), .rx_full(lnk.rx_full), .tx_empty(lnk.tx_empty),
    .wide_timer_overflow(lnk.wide_timer_overflow), .bor_reset(lnk.bor_reset),
    .narrow_timer_count(lnk.narrow_timer_count), .narrow_timer_period(lnk.narrow_timer_period));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hang();
    fails++;
    $display("ERROR handshake timeout");
    wrap_up();
  endtask
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (64) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask
  task automatic axi_rd(input logic [5:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (64) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd_word = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask
  task automatic bank_wr(input logic [7:0] a, input logic [7:0] d);
    axi_wr(`HOST_CMD, {15'h0000, 1'b1, a, d});
  endtask
  task automatic expect_reg(input string what, input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
    axi_wr(`HOST_CMD, {16'h0000, a, 8'h00});
    repeat (16) begin
      axi_rd(`HOST_DATA);
      if (rd_word[8] === 1'b0) begin
        chk8(what, x, rd_word[7:0] & m);
        return;
      end
    end
    hang();
  endtask
  task automatic ev_case(input logic [31:0] c, input logic [11:0] e, input logic [7:0] x,
                         input logic [7:0] a = `ADDR_FLAGS_ONE);
    axi_wr(`HOST_CTRL, c);
    bank_wr(`ADDR_FLAGS_ONE, 8'h00);
    bank_wr(`ADDR_FLAGS_TWO, 8'h00);
    axi_wr(`HOST_EVENT, {20'h00000, e});
    expect_reg("event flag", a, 8'hcf, x);
  endtask
  task automatic t_reset_state();
    expect_reg("flags two", `ADDR_FLAGS_TWO, 8'hff, 8'h00);
    expect_reg("cause", `ADDR_RESET_CAUSE, 8'hff, {6'h00, `POR_RST, `BOR_RST});
    expect_reg("unmapped", 8'h20, 8'hff, 8'h00);
    bank_wr(`ADDR_FLAGS_TWO, 8'hff);
    expect_reg("flags two", `ADDR_FLAGS_TWO, 8'hff, 8'h01);
    bank_wr(`ADDR_ENABLES_TWO, 8'hff);
    expect_reg("enables two", `ADDR_ENABLES_TWO, 8'hff, 8'h01);
    bank_wr(`ADDR_ENABLES_TWO, 8'h00);
    axi_rd(6'h10);
    chk8("axi read resp", {6'h00, `RESP_SLVERR}, {6'h00, resp});
    axi_wr(6'h14, 32'h0000_00ff);
    chk8("axi write resp", {6'h00, `RESP_SLVERR}, {6'h00, resp});
  endtask
  task automatic t_flag_events();
    ev_case(BASE, 12'h001, 8'h80);
    ev_case(BASE, 12'h002, 8'h40);
    ev_case(BASE, 12'h400, 8'h01);
    ev_case(BASE | 32'h04, 12'h040, 8'h04);
    ev_case(BASE | 32'h08, 12'h080, 8'h04);
    ev_case(BASE | 32'h04, 12'h080, 8'h00);
    ev_case(BASE | 32'h0c, 12'h0c0, 8'h00);
    ev_case(BASE | 32'h10, 12'h100, 8'h01, `ADDR_FLAGS_TWO);
    ev_case(BASE | 32'h20, 12'h200, 8'h01, `ADDR_FLAGS_TWO);
    ev_case(BASE | 32'h30, 12'h300, 8'h00, `ADDR_FLAGS_TWO);
    ev_case(32'h0202_0000, 12'h000, 8'h02);
    axi_wr(`HOST_CTRL, BASE);
    expect_reg("period flag", `ADDR_FLAGS_ONE, 8'h02, 8'h02);
  endtask
  task automatic t_serial();
    ev_case(BASE, 12'h004, 8'h08);
    ev_case(BASE | 32'h01, 12'h004, 8'h08);
    ev_case(BASE | 32'h02, 12'h004, 8'h08);
    ev_case(BASE | 32'h03, 12'h004, 8'h00);
    ev_case(BASE | 32'h02, 12'h008, 8'h08);
    ev_case(BASE, 12'h008, 8'h00);
    ev_case(BASE | 32'h42, 12'h010, 8'h08);
    ev_case(BASE | 32'h42, 12'h020, 8'h08);
    ev_case(BASE | 32'h02, 12'h010, 8'h00);
  endtask
  task automatic t_live_bits();
    axi_wr(`HOST_CTRL, BASE | 32'h80);
    bank_wr(`ADDR_FLAGS_ONE, 8'h10);
    expect_reg("live bits", `ADDR_FLAGS_ONE, 8'h30, 8'h20);
    axi_wr(`HOST_CTRL, BASE | 32'h100);
    bank_wr(`ADDR_FLAGS_ONE, 8'h20);
    expect_reg("live bits", `ADDR_FLAGS_ONE, 8'h30, 8'h10);
  endtask
  task automatic t_irq();
    ev_case(BASE, 12'h400, 8'h01);
    peripheral_enables_one <= 8'h01;
    for (int i = 0; i < 4; i++) begin
      global_irq_enable <= i[0];
      peripheral_group_enable <= i[1];
      @(negedge aclk);
      chk8("irq", {7'h00, i[0] & i[1]}, {7'h00, periph_irq});
      @(posedge aclk);
    end
    peripheral_enables_one <= 8'h00;
    ev_case(BASE | 32'h10, 12'h100, 8'h01, `ADDR_FLAGS_TWO);
    @(negedge aclk);
    chk8("irq", 8'h00, {7'h00, periph_irq});
    bank_wr(`ADDR_ENABLES_TWO, 8'h01);
    expect_reg("enables two", `ADDR_ENABLES_TWO, 8'hff, 8'h01);
    @(negedge aclk);
    chk8("irq", 8'h01, {7'h00, periph_irq});
  endtask
  task automatic t_reset_cause();
    bank_wr(`ADDR_RESET_CAUSE, 8'hff);
    expect_reg("cause", `ADDR_RESET_CAUSE, 8'hff, 8'h03);
    axi_wr(`HOST_EVENT, 32'h800);
    expect_reg("cause", `ADDR_RESET_CAUSE, 8'hff, 8'h03);
    brownout_detect_enable <= 1'b1;
    axi_wr(`HOST_EVENT, 32'h800);
    expect_reg("cause", `ADDR_RESET_CAUSE, 8'hff, 8'h02);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    expect_reg("cause", `ADDR_RESET_CAUSE, 8'hfe, 8'h00);
  endtask
  initial begin
    aresetn = 1'b0;
    global_irq_enable = 1'b0;
    peripheral_group_enable = 1'b0;
    peripheral_enables_one = 8'h00;
    brownout_detect_enable = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    fails = 0;
    checks_done = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_state();
    t_flag_events();
    t_serial();
    t_live_bits();
    t_irq();
    t_reset_cause();
    wrap_up();
  end
endmodule
